/* File: igcr_pkg.sv */
// Package for the gyro and common control register bank
package igcr_pkg;

    // Register offsets
    localparam logic [7:0] IGCR_OFS_RATE_SCALE = 8'h11;
    localparam logic [7:0] IGCR_OFS_IF_RESET   = 8'h12;
    localparam logic [7:0] IGCR_OFS_SLEEP_IRQ  = 8'h13;
    localparam logic [7:0] IGCR_OFS_SELFTEST   = 8'h14;
    localparam logic [7:0] IGCR_OFS_TRIGGER    = 8'h15;
    localparam logic [7:0] IGCR_OFS_GYRO_FILT  = 8'h16;

    // Reset values
    localparam logic [7:0] IGCR_RST_RATE_SCALE = 8'h00;
    localparam logic [7:0] IGCR_RST_IF_RESET   = 8'h04;
    localparam logic [7:0] IGCR_RST_SLEEP_IRQ  = 8'h00;
    localparam logic [7:0] IGCR_RST_SELFTEST   = 8'h00;
    localparam logic [7:0] IGCR_RST_TRIGGER    = 8'h00;
    localparam logic [7:0] IGCR_RST_GYRO_FILT  = 8'h00;

    // Writable bit masks; zero bits are not stored and read as zero, except the reboot bit, which reads busy
    localparam logic [7:0] IGCR_MSK_RATE_SCALE = 8'hfe;
    localparam logic [7:0] IGCR_MSK_IF_RESET   = 8'h7c;
    localparam logic [7:0] IGCR_MSK_SLEEP_IRQ  = 8'h6e;
    localparam logic [7:0] IGCR_MSK_SELFTEST   = 8'hef;
    localparam logic [7:0] IGCR_MSK_TRIGGER    = 8'hff;
    localparam logic [7:0] IGCR_MSK_GYRO_FILT  = 8'hf7;

    // Field positions
    localparam int IGCR_POS_REBOOT    = 7;
    localparam int IGCR_POS_SWRESET   = 0;
    localparam int IGCR_POS_BLOCK     = 6;
    localparam int IGCR_POS_POLARITY  = 5;
    localparam int IGCR_POS_DRIVE     = 4;
    localparam int IGCR_POS_WIRE      = 3;
    localparam int IGCR_POS_AUTOINC   = 2;

    // Codes
    localparam logic [3:0] IGCR_RATE_OFF     = 4'h0;
    localparam logic [3:0] IGCR_RATE_MAX     = 4'ha;
    localparam logic [3:0] IGCR_RATE_LP_MAX  = 4'h3;
    localparam logic [3:0] IGCR_RATE_NM_MAX  = 4'h5;
    localparam logic [1:0] IGCR_ST_NORMAL    = 2'h0;
    localparam logic [1:0] IGCR_ST_POS       = 2'h1;
    localparam logic [1:0] IGCR_ST_G_NEG     = 2'h3;
    localparam logic [1:0] IGCR_ACCEL_SELFTEST_CODE_NEG    = 2'h2;
    localparam logic [2:0] IGCR_TRG_EDGE     = 3'h4;
    localparam logic [2:0] IGCR_TRG_LEVEL    = 3'h2;
    localparam logic [2:0] IGCR_TRG_LATCH    = 3'h3;
    localparam logic [2:0] IGCR_TRG_FIFO     = 3'h6;

    // Cycles a self-clearing action request is held
    localparam int IGCR_PULSE_CYCLES = 1;

    typedef enum logic [1:0] {
        IGCR_PWR_DOWN,
        IGCR_PWR_LOW,
        IGCR_PWR_NORMAL,
        IGCR_PWR_HIGH
    } igcr_power_type;

    typedef enum logic [2:0] {
        IGCR_GYRO_LOW_RANGE_OVERRIDE,
        IGCR_FS_250,
        IGCR_FS_500,
        IGCR_FS_1000,
        IGCR_FS_2000
    } igcr_scale_type;

    typedef enum logic [2:0] {
        IGCR_TRIG_NONE,
        IGCR_TRIG_EDGE,
        IGCR_TRIG_LEVEL,
        IGCR_TRIG_LATCH,
        IGCR_TRIG_FIFO
    } igcr_trig_type;

    typedef enum logic [1:0] {
        IGCR_SELF_NORMAL,
        IGCR_SELF_POS,
        IGCR_SELF_NEG,
        IGCR_SELF_BAD
    } igcr_self_type;

    // Gyro chain settings
    typedef struct packed {
        igcr_power_type power;
        logic           rate_valid;
        logic [3:0]     rate_code;
        igcr_scale_type scale;
        logic           sleep;
        logic           lowpass_on;
        logic [2:0]     lowpass_bw;
        logic           highpass_on;
        logic [1:0]     highpass_cut;
        igcr_self_type  selftest;
        logic           stab_on;
    } igcr_gyro_type;

    // Shared interface and pin settings
    typedef struct packed {
        logic          update_block;
        logic          irq_active_low;
        logic          irq_open_drain;
        logic          three_wire;
        logic          auto_inc;
        logic          irq_merge;
        logic          ready_mask;
        logic [1:0]    burst_wrap;
        igcr_trig_type trig_mode;
        igcr_self_type accel_selftest;
        logic          accel_perf_off;
    } igcr_common_type;

    // Decode a self-test field; the two sensors encode negative differently
    function automatic igcr_self_type igcr_self_decode(
        input logic [1:0] code,
        input logic [1:0] neg_code
    );
        if (code == IGCR_ST_NORMAL) begin
            return IGCR_SELF_NORMAL;
        end else if (code == IGCR_ST_POS) begin
            return IGCR_SELF_POS;
        end else if (code == neg_code) begin
            return IGCR_SELF_NEG;
        end else begin
            return IGCR_SELF_BAD;
        end
    endfunction

endpackage

/* File: igcr_regs.sv */
// Gyro and common control register bank with decoded settings
`timescale 1ns/1ns

//
// Operation
// [R01] Gyro rate code, zero is power-down, 1011 unavailable
// [R02] Perf-disable picks low/normal/high by rate
// [R03] Two-bit range code selects 250..2000 dps
// [R04] Low-range override forces 125 dps
// [R05] Reboot bit pulses reload, then self-clears
// [R06] Update-block holds pairs until both bytes read
// [R07] Polarity bit makes interrupt pins active low
// [R08] Drive bit makes interrupt pins open-drain
// [R09] Wire bit selects 3-wire or 4-wire serial
// [R10] Auto-increment bit, reset one, advances address
// [R11] Soft reset bit resets device, self-clears
// [R12] Sleep bit puts gyro in sleep
// [R13] Merge bit ORs all interrupts onto first pin
// [R14] Ready mask hides data-ready until settling
// [R15] First lowpass only while auxiliary port off
// [R16] Burst wrap code selects wrapped sensors
// [R17] Gyro self-test codes, 10 not allowed
// [R18] Accel self-test codes, 11 not allowed
// [R19] Three trigger bits select trigger mode
// [R20] Accel perf-disable bit turns off high performance
// [R21] Highpass needs enable and high-performance gyro
// [R22] Stab chain on bit used when source selected
// [R23] Host keeps filter register bit 3 zero
// [R24] Byte registers read back, soft reset reads zero, reboot reads busy
module igcr_regs
    import igcr_pkg::*;
(
    // Clock and reset
    input  wire logic            clock_in,
    input  wire logic            rst_in,
    // Register port from the serial interface
    input  wire logic            reg_wr_in,
    input  wire logic            reg_rd_in,
    input  wire logic [7:0]      reg_addr_in,
    input  wire logic [7:0]      reg_wdata_in,
    output logic      [7:0]      reg_rdata_out,
    output logic                 reg_hit_out,
    // Device status
    input  wire logic            aux_port_enable_in,
    input  wire logic            reboot_done_in,
    // Decoded settings
    output igcr_gyro_type        gyro_cfg_out,
    output igcr_common_type      common_cfg_out,
    output logic                 reboot_req_out,
    output logic                 soft_reset_req_out,
    // Interrupt pin shaping
    input  wire logic            irq_first_src_in,
    input  wire logic            irq_second_src_in,
    output logic                 irq_first_out,
    output logic                 irq_first_oe_out,
    output logic                 irq_second_out,
    output logic                 irq_second_oe_out
);

    localparam int NREG = 6;

    logic [7:0] regs_q [NREG];
    logic       reboot_busy_q;

    function automatic logic [7:0] reg_mask(input int idx);
        case (idx)
            0:       return IGCR_MSK_RATE_SCALE;
            1:       return IGCR_MSK_IF_RESET;
            2:       return IGCR_MSK_SLEEP_IRQ;
            3:       return IGCR_MSK_SELFTEST;
            4:       return IGCR_MSK_TRIGGER;
            default: return IGCR_MSK_GYRO_FILT;
        endcase
    endfunction

    function automatic logic [7:0] reg_reset(input int idx);
        case (idx)
            0:       return IGCR_RST_RATE_SCALE;
            1:       return IGCR_RST_IF_RESET;
            2:       return IGCR_RST_SLEEP_IRQ;
            3:       return IGCR_RST_SELFTEST;
            4:       return IGCR_RST_TRIGGER;
            default: return IGCR_RST_GYRO_FILT;
        endcase
    endfunction

    // Index of an offset in the bank, or NREG when unmapped
    function automatic int reg_index(input logic [7:0] addr);
        if (addr >= IGCR_OFS_RATE_SCALE && addr <= IGCR_OFS_GYRO_FILT) begin
            return int'(addr - IGCR_OFS_RATE_SCALE);
        end
        return NREG;
    endfunction

    // Stored fields; bit 3 of the filter register is kept zero in case
    // the host breaks its side of the contract
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    regs_q[gi] <= reg_reset(gi); // [R10]
                end else if (soft_reset_req_out) begin
                    regs_q[gi] <= reg_reset(gi); // [R11]
                end else if (reg_wr_in && reg_index(reg_addr_in) == gi) begin
                    regs_q[gi] <= reg_wdata_in & reg_mask(gi); // [R24] [R23]
                end
            end
        end
    endgenerate

    // Self-clearing actions: a one written starts a single request pulse
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            soft_reset_req_out <= 1'b0;
        end else begin
            soft_reset_req_out <= reg_wr_in && !soft_reset_req_out &&
                reg_addr_in == IGCR_OFS_IF_RESET &&
                reg_wdata_in[IGCR_POS_SWRESET]; // [R11]
        end
    end

    // Reboot pulse; the bit reads one until the reload reports done or a soft reset request clears it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reboot_req_out <= 1'b0;
            reboot_busy_q  <= 1'b0;
        end else begin
            reboot_req_out <= 1'b0;
            if (reg_wr_in && reg_addr_in == IGCR_OFS_IF_RESET &&
                reg_wdata_in[IGCR_POS_REBOOT] && !reboot_busy_q) begin
                reboot_req_out <= 1'b1; // [R05]
                reboot_busy_q  <= 1'b1;
            end else if (reboot_done_in || soft_reset_req_out) begin
                reboot_busy_q  <= 1'b0; // [R05]
            end
        end
    end

    // Read port, registered; unmapped offsets return zero, hit low
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_hit_out   <= 1'b0;
        end else if (reg_rd_in) begin
            if (reg_index(reg_addr_in) < NREG) begin
                reg_rdata_out <= regs_q[reg_index(reg_addr_in)]; // [R24]
                if (reg_addr_in == IGCR_OFS_IF_RESET) begin
                    reg_rdata_out[IGCR_POS_REBOOT] <= reboot_busy_q;
                end
                reg_hit_out <= 1'b1;
            end else begin
                reg_rdata_out <= 8'h00;
                reg_hit_out   <= 1'b0;
            end
        end
    end

    // Field views
    logic [3:0] rate_code;
    logic [1:0] range_code;
    logic       low_range;
    logic       perf_off;
    igcr_power_type power;
    logic [2:0] trig_bits;

    assign rate_code  = regs_q[0][7:4];
    assign range_code = regs_q[0][3:2];
    assign low_range  = regs_q[0][1];
    assign perf_off   = regs_q[5][7];
    assign trig_bits  = regs_q[4][7:5];

    always_comb begin
        if (rate_code == IGCR_RATE_OFF || rate_code > IGCR_RATE_MAX) begin
            power = IGCR_PWR_DOWN; // [R01]
        end else if (!perf_off) begin
            power = IGCR_PWR_HIGH; // [R02]
        end else if (rate_code <= IGCR_RATE_LP_MAX) begin
            power = IGCR_PWR_LOW; // [R02]
        end else if (rate_code <= IGCR_RATE_NM_MAX) begin
            power = IGCR_PWR_NORMAL; // [R02]
        end else begin
            power = IGCR_PWR_HIGH; // [R02]
        end
    end

    // Gyro settings, registered so downstream sees clean levels
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gyro_cfg_out <= '0;
        end else begin
            gyro_cfg_out.power      <= power;
            gyro_cfg_out.rate_code  <= rate_code;
            gyro_cfg_out.rate_valid <= rate_code <= IGCR_RATE_MAX; // [R01]
            if (low_range) begin
                gyro_cfg_out.scale <= IGCR_GYRO_LOW_RANGE_OVERRIDE; // [R04]
            end else begin
                case (range_code)
                    2'h0:    gyro_cfg_out.scale <= IGCR_FS_250; // [R03]
                    2'h1:    gyro_cfg_out.scale <= IGCR_FS_500;
                    2'h2:    gyro_cfg_out.scale <= IGCR_FS_1000;
                    default: gyro_cfg_out.scale <= IGCR_FS_2000;
                endcase
            end
            gyro_cfg_out.sleep      <= regs_q[2][6]; // [R12]
            gyro_cfg_out.lowpass_on <= regs_q[2][1] &&
                !aux_port_enable_in; // [R15]
            gyro_cfg_out.lowpass_bw <= regs_q[4][2:0]; // [R15]
            // Highpass only in high-performance mode
            gyro_cfg_out.highpass_on <= regs_q[5][6] &&
                power == IGCR_PWR_HIGH; // [R21]
            gyro_cfg_out.highpass_cut <= regs_q[5][5:4]; // [R21]
            gyro_cfg_out.selftest <= igcr_self_decode(regs_q[3][3:2],
                IGCR_ST_G_NEG); // [R17]
            // Source-select zero leaves the chain to the auxiliary port
            gyro_cfg_out.stab_on <= regs_q[5][2] && regs_q[5][0]; // [R22]
        end
    end

    // Shared settings
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            common_cfg_out <= '0;
            common_cfg_out.auto_inc <= 1'b1; // [R10]
        end else begin
            common_cfg_out.update_block <= regs_q[1][IGCR_POS_BLOCK]; // [R06]
            common_cfg_out.irq_active_low <=
                regs_q[1][IGCR_POS_POLARITY]; // [R07]
            common_cfg_out.irq_open_drain <=
                regs_q[1][IGCR_POS_DRIVE]; // [R08]
            common_cfg_out.three_wire <= regs_q[1][IGCR_POS_WIRE]; // [R09]
            common_cfg_out.auto_inc <= regs_q[1][IGCR_POS_AUTOINC]; // [R10]
            common_cfg_out.irq_merge  <= regs_q[2][5]; // [R13]
            common_cfg_out.ready_mask <= regs_q[2][3]; // [R14]
            common_cfg_out.burst_wrap <= regs_q[3][6:5]; // [R16]
            case (trig_bits)
                IGCR_TRG_EDGE:  common_cfg_out.trig_mode <= IGCR_TRIG_EDGE;
                IGCR_TRG_LEVEL: common_cfg_out.trig_mode <= IGCR_TRIG_LEVEL;
                IGCR_TRG_LATCH: common_cfg_out.trig_mode <= IGCR_TRIG_LATCH;
                IGCR_TRG_FIFO:  common_cfg_out.trig_mode <= IGCR_TRIG_FIFO;
                default:        common_cfg_out.trig_mode <= IGCR_TRIG_NONE;
            endcase // [R19]
            common_cfg_out.accel_selftest <= igcr_self_decode(
                regs_q[3][1:0], IGCR_ACCEL_SELFTEST_CODE_NEG); // [R18]
            common_cfg_out.accel_perf_off <= regs_q[4][4]; // [R20]
        end
    end

    // Interrupt pins: route, then polarity, then drive style
    logic irq_first_act;
    logic irq_second_act;
    logic irq_low;
    logic irq_od;

    assign irq_low = regs_q[1][IGCR_POS_POLARITY];
    assign irq_od  = regs_q[1][IGCR_POS_DRIVE];
    assign irq_first_act = irq_first_src_in ||
        (regs_q[2][5] && irq_second_src_in); // [R13]
    assign irq_second_act = irq_second_src_in && !regs_q[2][5]; // [R13]

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_first_out     <= 1'b0;
            irq_first_oe_out  <= 1'b1;
            irq_second_out    <= 1'b0;
            irq_second_oe_out <= 1'b1;
        end else begin
            irq_first_out  <= irq_first_act ^ irq_low; // [R07]
            irq_second_out <= irq_second_act ^ irq_low; // [R07]
            // Open drain drives only the pulled-down level
            irq_first_oe_out  <= !irq_od ||
                !(irq_first_act ^ irq_low); // [R08]
            irq_second_oe_out <= !irq_od ||
                !(irq_second_act ^ irq_low); // [R08]
        end
    end

endmodule

/* File: igcr_regs_sva.sv */
// Assertion checker for the gyro and common control register bank
`timescale 1ns/1ns
module igcr_chk
    import igcr_pkg::*;
(
    // Clock and reset
    input wire logic            clock_in,
    input wire logic            rst_in,
    // Register port
    input wire logic            reg_wr_in,
    input wire logic            reg_rd_in,
    input wire logic [7:0]      reg_addr_in,
    input wire logic [7:0]      reg_wdata_in,
    input wire logic [7:0]      reg_rdata_out,
    input wire logic            reg_hit_out,
    // Settings
    input wire igcr_gyro_type   gyro_cfg_out,
    input wire igcr_common_type common_cfg_out,
    input wire logic            soft_reset_req_out,
    // Interrupt pin
    input wire logic            irq_first_src_in,
    input wire logic            irq_second_src_in,
    input wire logic            irq_first_out,
    input wire logic            irq_first_oe_out
);
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;

    // Write data delayed to line up with the settings outputs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wd1_q <= 8'h00;
            wd2_q <= 8'h00;
        end else begin
            wd1_q <= reg_wdata_in;
            wd2_q <= wd1_q;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    // A lone write; a following write would shift the delayed data
    sequence s_wr(logic [7:0] ofs, logic ok);
        reg_wr_in && reg_addr_in == ofs && ok ##1 !reg_wr_in;
    endsequence

    chk_rate_decode: assert property (
        s_wr(IGCR_OFS_RATE_SCALE, 1'b1)
        |-> ##1 gyro_cfg_out.rate_code == wd2_q[7:4] && gyro_cfg_out.scale ==
        (wd2_q[1] ? IGCR_GYRO_LOW_RANGE_OVERRIDE : igcr_scale_type'(3'h1 + wd2_q[3:2])))
        else $error("gyro rate or range decode wrong");
    chk_iface_bits: assert property (
        s_wr(IGCR_OFS_IF_RESET, !reg_wdata_in[0])
        |-> ##1 {common_cfg_out.update_block, common_cfg_out.irq_active_low,
        common_cfg_out.irq_open_drain, common_cfg_out.three_wire,
        common_cfg_out.auto_inc} == wd2_q[6:2])
        else $error("interface option bits wrong");
    chk_irq_level: assert property ($stable(common_cfg_out) |->
        irq_first_out == (common_cfg_out.irq_active_low ^
        ($past(irq_first_src_in) |
        common_cfg_out.irq_merge & $past(irq_second_src_in))))
        else $error("first interrupt pin level wrong");
    chk_irq_drive: assert property ($stable(common_cfg_out) |->
        irq_first_oe_out == !(common_cfg_out.irq_open_drain && irq_first_out))
        else $error("first interrupt pin enable wrong");
    chk_read_unmapped: assert property (reg_rd_in &&
        !(reg_addr_in inside {[IGCR_OFS_RATE_SCALE:IGCR_OFS_GYRO_FILT]})
        |=> !reg_hit_out && reg_rdata_out == 8'h00)
        else $error("unmapped read not refused");
    chk_soft_pulse: assert property (soft_reset_req_out |->
        $past(reg_wr_in && reg_addr_in == IGCR_OFS_IF_RESET && reg_wdata_in[0])
        ##1 !soft_reset_req_out)
        else $error("soft reset pulse without cause or too long");
    chk_soft_clears: assert property (soft_reset_req_out |-> ##2
        gyro_cfg_out.rate_code == 4'h0 && common_cfg_out.auto_inc)
        else $error("soft reset left settings in place");
    chk_hp_gate: assert property (gyro_cfg_out.highpass_on |->
        gyro_cfg_out.power == IGCR_PWR_HIGH)
        else $error("highpass on outside high performance");
endmodule

bind igcr_regs igcr_chk u_chk (
    .clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .gyro_cfg_out(gyro_cfg_out),
    .common_cfg_out(common_cfg_out), .soft_reset_req_out(soft_reset_req_out),
    .irq_first_src_in(irq_first_src_in),
    .irq_second_src_in(irq_second_src_in), .irq_first_out(irq_first_out),
    .irq_first_oe_out(irq_first_oe_out)
);

/* File: igcr_host.sv */
// Host model issuing byte accesses to the control bank
`timescale 1ns/1ns
module igcr_host
    import igcr_pkg::*;
(
    // Clock
    input  wire logic       clock_in,
    // Register access port
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // Idle lines show the inverse so a stale value never passes
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == IGCR_OFS_GYRO_FILT) ? (d & 8'hf7) : d;
        @(posedge clock_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = v;
        reg_wr_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~v;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        #1;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rdata_in;
    endtask
endmodule

/* File: tb_top.sv */
// Testbench for the gyro and common control register bank
`timescale 1ns/1ns
module tb_top
    import igcr_pkg::*;
;
    logic            clock_in, rst_in, reg_wr, reg_rd, hit, aux_on, boot_done;
    logic            src1, src2, pin1, oe1, pin2, oe2, reboot_req, soft_req;
    logic [7:0]      reg_addr, reg_wdata, rdata;
    igcr_gyro_type   gcfg;
    igcr_common_type ccfg;
    int              fails;
    int              num_checks;

    localparam logic [7:0] RSTV [6] = '{IGCR_RST_RATE_SCALE, IGCR_RST_IF_RESET,
        IGCR_RST_SLEEP_IRQ, IGCR_RST_SELFTEST, IGCR_RST_TRIGGER,
        IGCR_RST_GYRO_FILT};
    localparam logic [7:0] MSKV [6] = '{IGCR_MSK_RATE_SCALE, IGCR_MSK_IF_RESET,
        IGCR_MSK_SLEEP_IRQ, IGCR_MSK_SELFTEST, IGCR_MSK_TRIGGER,
        IGCR_MSK_GYRO_FILT};
    localparam igcr_self_type G_ST [4] = '{IGCR_SELF_NORMAL, IGCR_SELF_POS,
        IGCR_SELF_BAD, IGCR_SELF_NEG};
    localparam igcr_self_type XL_ST [4] = '{IGCR_SELF_NORMAL, IGCR_SELF_POS,
        IGCR_SELF_NEG, IGCR_SELF_BAD};
    localparam logic [2:0] TRG_CODE [5] = '{IGCR_TRG_EDGE, IGCR_TRG_LEVEL,
        IGCR_TRG_LATCH, IGCR_TRG_FIFO, 3'h0};
    localparam igcr_trig_type TRG_MODE [5] = '{IGCR_TRIG_EDGE, IGCR_TRIG_LEVEL,
        IGCR_TRIG_LATCH, IGCR_TRIG_FIFO, IGCR_TRIG_NONE};

    igcr_regs DUT (
        .clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .reg_hit_out(hit), .aux_port_enable_in(aux_on),
        .reboot_done_in(boot_done), .gyro_cfg_out(gcfg), .common_cfg_out(ccfg),
        .reboot_req_out(reboot_req), .soft_reset_req_out(soft_req),
        .irq_first_src_in(src1), .irq_second_src_in(src2),
        .irq_first_out(pin1), .irq_first_oe_out(oe1),
        .irq_second_out(pin2), .irq_second_oe_out(oe2)
    );

    igcr_host u_host (
        .clock_in(clock_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_rdata_in(rdata)
    );

    initial clock_in = 1'b0;
    always #4 clock_in = ~clock_in;

    task automatic check_val(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        check_val("read data", exp, d);
        check_val("read hit", {7'h0, a inside {[8'h11:8'h16]}}, {7'h0, hit});
    endtask

    // Settings land one edge after the write edge; wait two
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write(a, d);
        repeat (2) @(posedge clock_in);
        #1;
    endtask

    function automatic logic [1:0] exp_pow(input int c, input int off);
        if (c == 0 || c > 10) return IGCR_PWR_DOWN;
        if (off != 0 && c < 4) return IGCR_PWR_LOW;
        if (off != 0 && c < 6) return IGCR_PWR_NORMAL;
        return IGCR_PWR_HIGH;
    endfunction

    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Tests need a few hundred cycles; this is ample margin
    initial begin
        #400000;
        fails++;
        results();
    end

    initial begin
        int i;
        int p;
        logic [7:0] v;
        fails = 0;
        num_checks = 0;
        rst_in = 1'b1;
        aux_on = 1'b0;
        boot_done = 1'b0;
        src1 = 1'b0;
        src2 = 1'b0;
        repeat (10) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        check_reg(8'h10, 8'h00);
        check_reg(8'h17, 8'h00);
        for (i = 0; i < 6; i++) begin
            check_reg(8'h11 + 8'(i), RSTV[i]);
            v = (i == 1) ? 8'h7c : 8'hff;
            u_host.write(8'h11 + 8'(i), v);
            check_reg(8'h11 + 8'(i), MSKV[i] & v);
        end
        $display("TEST reset and readback done");
        for (p = 0; p < 2; p++) begin
            wr(8'h16, {p[0], 7'h00});
            for (i = 0; i < 12; i++) begin
                wr(8'h11, {i[3:0], 4'h0});
                check_val("power", 8'(exp_pow(i, p)), 8'(gcfg.power));
                check_val("rate valid", 8'(i < 11),
                    8'(gcfg.rate_valid));
            end
        end
        for (i = 0; i < 8; i++) begin
            wr(8'h11, {4'h6, i[1:0], i[2], 1'b0});
            v = i[2] ? 8'(IGCR_GYRO_LOW_RANGE_OVERRIDE) : 8'(IGCR_FS_250) + 8'(i[1:0]);
            check_val("scale", v, 8'(gcfg.scale));
        end
        $display("TEST rate and range done");
        for (i = 0; i < 4; i++) begin
            wr(8'h14, {1'b0, i[1:0], 1'b0, i[1:0], i[1:0]});
            check_val("gyro selftest", 8'(G_ST[i]), 8'(gcfg.selftest));
            check_val("accel selftest", 8'(XL_ST[i]),
                8'(ccfg.accel_selftest));
            check_val("burst wrap", 8'(i), 8'(ccfg.burst_wrap));
        end
        for (i = 0; i < 5; i++) begin
            wr(8'h15, {TRG_CODE[i], i[0], 1'b0, i[2:0]});
            check_val("trigger", 8'(TRG_MODE[i]), 8'(ccfg.trig_mode));
            check_val("accel perf", 8'(i[0]), 8'(ccfg.accel_perf_off));
            check_val("lowpass bw", 8'(i), 8'(gcfg.lowpass_bw));
        end
        $display("TEST selftest and trigger done");
        for (i = 0; i < 2; i++) begin
            aux_on = i[0];
            wr(8'h13, 8'h6a);
            check_val("sleep irq fields", {4'h0, 3'h7, i == 0}, {4'h0,
                gcfg.sleep, ccfg.irq_merge, ccfg.ready_mask,
                gcfg.lowpass_on});
        end
        wr(8'h11, 8'h60);
        wr(8'h16, 8'h61);
        check_val("stab chain off", 8'h00, 8'(gcfg.stab_on));
        wr(8'h16, 8'h65);
        check_val("highpass", 8'h06, {5'h0, gcfg.highpass_on,
            gcfg.highpass_cut});
        check_val("stab chain on", 8'h01, 8'(gcfg.stab_on));
        wr(8'h16, 8'hc0);
        wr(8'h11, 8'h20);
        check_val("highpass low power", 8'h00, 8'(gcfg.highpass_on));
        $display("TEST filters done");
        wr(8'h13, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(8'h12, {2'b00, i[0], i[1], 4'h4});
            src1 = i[2];
            src2 = !i[2];
            wr(8'h18, 8'h00);
            check_val("irq pins", {6'h0, i[2] ^ i[0], !i[2] ^ i[0]},
                {6'h0, pin1, pin2});
            check_val("irq enable", {6'h0, !(i[1] && (i[2] ^ i[0])),
                !(i[1] && (!i[2] ^ i[0]))}, {6'h0, oe1, oe2});
        end
        src1 = 1'b0;
        src2 = 1'b1;
        wr(8'h13, 8'h20);
        check_val("merged pin", 8'h01, {6'h0, pin1, pin2});
        $display("TEST interrupt pins done");
        src2 = 1'b0;
        wr(8'h12, 8'h04);
        wr(8'h11, 8'h60);
        u_host.write(8'h12, 8'h01);
        check_val("soft pulse", 8'h01, 8'(soft_req));
        check_reg(8'h11, IGCR_RST_RATE_SCALE);
        check_reg(8'h12, IGCR_RST_IF_RESET);
        u_host.write(8'h12, 8'h84);
        check_val("reboot pulse", 8'h01, 8'(reboot_req));
        check_reg(8'h12, 8'h84);
        boot_done = 1'b1;
        @(posedge clock_in);
        #1;
        boot_done = 1'b0;
        check_reg(8'h12, 8'h04);
        $display("TEST soft reset and reboot done");
        results();
    end
endmodule
